// file: inc/irq_ctrl_pkg.sv
/*
 * package for the four level interrupt controller: register offsets,
 * source numbering, field positions, reset values and carrier structs.
 * assumes a 32-bit apb slave with one aligned word per register.
 */
package irq_ctrl_pkg;

    // ========================================
    // sizes
    localparam int NumSrc   = 10;
    localparam int LvlW     = 2;
    localparam int SrcW     = 4;
    localparam int AddrW    = 12;
    localparam int NestW    = 3;

    // ========================================
    // register byte addresses
    localparam logic [AddrW-1:0] EnPrimaryOff   = 12'h0a8;
    localparam logic [AddrW-1:0] EnSecondaryOff = 12'h0b1 << 2;
    localparam logic [AddrW-1:0] PrioLowOff     = 12'h0b8;
    localparam logic [AddrW-1:0] PrioHighOff    = 12'h0b7 << 2;
    localparam logic [AddrW-1:0] PrioLow2Off    = 12'h300;
    localparam logic [AddrW-1:0] PrioHigh2Off   = 12'h304;
    localparam logic [AddrW-1:0] StatusOff      = 12'h308;
    localparam logic [AddrW-1:0] MaskOff        = 12'h30c;
    localparam logic [AddrW-1:0] BitOpOff       = 12'h310;
    localparam logic [AddrW-1:0] ServiceOff     = 12'h314;

    // ========================================
    // global enable bit position and enable field widths
    localparam int GlobalEnBit = 7;
    localparam int PrimaryBits = 7;
    localparam int SecondBits  = 4;

    // ========================================
    // source numbering, also the polling order (lower wins)
    localparam logic [SrcW-1:0] SrcExt0    = 4'h0;
    localparam logic [SrcW-1:0] SrcTimer0  = 4'h1;
    localparam logic [SrcW-1:0] SrcExt1    = 4'h2;
    localparam logic [SrcW-1:0] SrcTimer1  = 4'h3;
    localparam logic [SrcW-1:0] SrcSerial0 = 4'h4;
    localparam logic [SrcW-1:0] SrcTimer2  = 4'h5;
    localparam logic [SrcW-1:0] SrcCounter = 4'h6;
    localparam logic [SrcW-1:0] SrcKeybd   = 4'h7;
    localparam logic [SrcW-1:0] SrcSpi     = 4'h8;
    localparam logic [SrcW-1:0] SrcSerial1 = 4'h9;

    // ========================================
    // reset values
    localparam logic [7:0] EnPrimaryRst = 8'h00;
    localparam logic [7:0] ByteRst      = 8'h00;
    localparam logic [NumSrc-1:0] SrcRst = 10'h000;

    // bit operation word: [7] set/clear, [3:0] bit index
    localparam int BitOpValBit = 7;

    // ========================================
    // carriers
    typedef struct packed {
        logic            valid;
        logic [SrcW-1:0] source;
        logic [LvlW-1:0] level;
    } grant_s;

    typedef struct packed {
        logic [NumSrc-1:0] low;
        logic [NumSrc-1:0] high;
    } prio_s;

endpackage

// file: core/irq_priority_pick.sv
/*
 * combinational pick of the winning request: highest level first, then
 * lowest source index as the polling order.
 * assumes requests already gated by the enables.
 */
`timescale 1ns/1ps

module irq_priority_pick
(
    // gated requests and priority bits
    input  wire logic [irq_ctrl_pkg::NumSrc-1:0] req,
    input  wire irq_ctrl_pkg::prio_s             prio,
    // winner
    output irq_ctrl_pkg::grant_s                 win
);

    // ========================================
    // per source level decode
    logic [irq_ctrl_pkg::LvlW-1:0] lvl [irq_ctrl_pkg::NumSrc];

    genvar g;
    generate
        for (g = 0; g < irq_ctrl_pkg::NumSrc; g++)
        begin : gLvl
            assign lvl[g] = {prio.high[g], prio.low[g]}; // RULE5
        end
    endgenerate

    // scan from last to first so the lowest index wins ties
    always_comb
    begin
        win = '0;
        for (int i = irq_ctrl_pkg::NumSrc - 1; i >= 0; i--)
        begin
            if (req[i] && (!win.valid || lvl[i] >= win.level)) // RULE8 RULE9
            begin
                win.valid  = 1'b1;
                win.source = i[irq_ctrl_pkg::SrcW-1:0];
                win.level  = lvl[i];
            end
        end
    end

endmodule

// file: core/four_level_interrupt_controller.sv
/*
 * four level interrupt controller: ten sources, enables, priority
 * registers, nesting record and vector request toward the cpu.
 * assumes source requests are synchronous levels on clk and the cpu
 * pulses ack when it takes a vector and reti when a handler ends.
 */
// Operation
// RULE1 - there are ten request sources, each with its own vector number.
// RULE2 - a source with its enable cleared never raises a request to the cpu; the code still sets its status bit on a rising edge, which can raise eventIrq.
// RULE3 - bit 7 of the primary enable register blocks every source while it is clear; the code gates cpuIrq with it but not eventIrq.
// RULE4 - each source takes one of four levels from one low and one high priority bit.
// RULE5 - the high and low bit pair read as a binary level, 00 lowest and 11 highest.
// RULE6 - a handler runs on until a strictly higher level request arrives.
// RULE7 - a handler at the highest level is never preempted.
// RULE8 - of simultaneous requests the higher level wins.
// RULE9 - among equal levels a fixed polling order picks the winner.
// RULE10 - primary enable bits 6 to 0 are counter array, timer 2, serial, timer 1, ext 1, timer 0, ext 0.
// RULE11 - primary enable resets to zero and allows single bit set and clear.
// RULE12 - the low priority register uses the same seven bit positions.
// RULE13 - the high priority register uses those positions and resets clear.
// RULE14 - the secondary enable holds serial 1, spi, two wire and keyboard in bits 3 to 0.
// RULE15 - in-service levels form a nesting record popped on return from interrupt.
`timescale 1ns/1ps

module four_level_interrupt_controller
(
    // clock and reset
    input  wire logic                            clk,
    input  wire logic                            srst,
    // apb slave
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [irq_ctrl_pkg::AddrW-1:0]  paddr,
    input  wire logic [31:0]                     pwdata,
    output logic [31:0]                          prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    // source requests, see package numbering
    input  wire logic [irq_ctrl_pkg::NumSrc-1:0] srcReq,
    input  wire logic                            twoWireReq,
    // cpu side
    output logic                                 cpuIrq,
    output logic [irq_ctrl_pkg::SrcW-1:0]        cpuVector,
    output logic [irq_ctrl_pkg::LvlW-1:0]        cpuLevel,
    input  wire logic                            cpuAck,
    input  wire logic                            cpuReti,
    // event summary interrupt
    output logic                                 eventIrq
);

    // ========================================
    // registers
    logic [7:0]                        enPrimary_q;
    logic [3:0]                        enSecondary_q;
    logic [6:0]                        prioLow_q;
    logic [6:0]                        prioHigh_q;
    logic [2:0]                        prioLow2_q;
    logic [2:0]                        prioHigh2_q;
    logic [irq_ctrl_pkg::NumSrc-1:0]   status_q;
    logic [irq_ctrl_pkg::NumSrc-1:0]   mask_q;
    logic [3:0]                        inService_q;
    logic [irq_ctrl_pkg::NestW-1:0]    depth_q;
    logic [irq_ctrl_pkg::NumSrc-1:0]   reqPrev_q;

    logic [irq_ctrl_pkg::NumSrc-1:0]   srcEn;
    logic [irq_ctrl_pkg::NumSrc-1:0]   gatedReq;
    irq_ctrl_pkg::prio_s               prio;
    irq_ctrl_pkg::grant_s              win;
    logic [irq_ctrl_pkg::LvlW-1:0]     curLevel;
    logic                              preemptOk;
    logic                              wrAcc;
    logic                              rdAcc;
    logic                              mapped;
    logic [31:0]                       rdData;
    logic [3:0]                        bitIdx;
    logic                              bitVal;
    logic                              bitOp;

    // ========================================
    // apb decode, zero wait state
    assign wrAcc  = psel && penable && pwrite;
    assign rdAcc  = psel && penable && !pwrite;
    assign bitOp  = wrAcc && paddr == irq_ctrl_pkg::BitOpOff;
    assign bitIdx = pwdata[3:0];
    assign bitVal = pwdata[irq_ctrl_pkg::BitOpValBit];

    // map enables onto the source numbering
    assign srcEn[irq_ctrl_pkg::SrcExt0]    = enPrimary_q[0]; // RULE10
    assign srcEn[irq_ctrl_pkg::SrcTimer0]  = enPrimary_q[1];
    assign srcEn[irq_ctrl_pkg::SrcExt1]    = enPrimary_q[2];
    assign srcEn[irq_ctrl_pkg::SrcTimer1]  = enPrimary_q[3];
    assign srcEn[irq_ctrl_pkg::SrcSerial0] = enPrimary_q[4];
    assign srcEn[irq_ctrl_pkg::SrcTimer2]  = enPrimary_q[5];
    assign srcEn[irq_ctrl_pkg::SrcCounter] = enPrimary_q[6];
    assign srcEn[irq_ctrl_pkg::SrcKeybd]   = enSecondary_q[0]; // RULE14
    assign srcEn[irq_ctrl_pkg::SrcSpi]     = enSecondary_q[2];
    assign srcEn[irq_ctrl_pkg::SrcSerial1] = enSecondary_q[3];

    // gate with own enable and global enable
    assign gatedReq = srcReq & srcEn & {irq_ctrl_pkg::NumSrc{enPrimary_q[irq_ctrl_pkg::GlobalEnBit]}}; // RULE2 RULE3 RULE1

    // priority pairs per source
    assign prio.low  = {prioLow2_q, prioLow_q};   // RULE12 RULE4
    assign prio.high = {prioHigh2_q, prioHigh_q}; // RULE13

    // ========================================
    // winner among gated requests
    irq_priority_pick uPick
    (
        .req  (gatedReq),
        .prio (prio),
        .win  (win)
    );

    // highest level in service
    always_comb
    begin
        curLevel = '0;
        for (int i = 0; i < 4; i++)
        begin
            if (inService_q[i])
            begin
                curLevel = i[irq_ctrl_pkg::LvlW-1:0];
            end
        end
    end

    // a winner may only interrupt a strictly lower running level
    assign preemptOk = win.valid && (depth_q == '0 || win.level > curLevel); // RULE6 RULE7

    // ========================================
    // primary enable with bit set and clear
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            enPrimary_q <= irq_ctrl_pkg::EnPrimaryRst; // RULE11
        end
        else if (wrAcc && paddr == irq_ctrl_pkg::EnPrimaryOff)
        begin
            enPrimary_q <= pwdata[7:0];
        end
        else if (bitOp && bitIdx <= 4'h7)
        begin
            enPrimary_q[bitIdx[2:0]] <= bitVal; // RULE11
        end
    end

    // secondary enable, two wire bit held for its own block
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            enSecondary_q <= '0;
        end
        else if (wrAcc && paddr == irq_ctrl_pkg::EnSecondaryOff)
        begin
            enSecondary_q <= pwdata[irq_ctrl_pkg::SecondBits-1:0]; // RULE14
        end
    end

    // priority registers
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            prioLow_q   <= '0;
            prioHigh_q  <= '0; // RULE13
            prioLow2_q  <= '0;
            prioHigh2_q <= '0;
        end
        else if (wrAcc)
        begin
            if (paddr == irq_ctrl_pkg::PrioLowOff)
            begin
                prioLow_q <= pwdata[irq_ctrl_pkg::PrimaryBits-1:0];
            end
            if (paddr == irq_ctrl_pkg::PrioHighOff)
            begin
                prioHigh_q <= pwdata[irq_ctrl_pkg::PrimaryBits-1:0];
            end
            if (paddr == irq_ctrl_pkg::PrioLow2Off)
            begin
                prioLow2_q <= pwdata[2:0];
            end
            if (paddr == irq_ctrl_pkg::PrioHigh2Off)
            begin
                prioHigh2_q <= pwdata[2:0];
            end
        end
    end

    // ========================================
    // sticky event status, set wins over write one to clear
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            status_q  <= irq_ctrl_pkg::SrcRst;
            reqPrev_q <= irq_ctrl_pkg::SrcRst;
        end
        else
        begin
            reqPrev_q <= srcReq;
            if (wrAcc && paddr == irq_ctrl_pkg::StatusOff)
            begin
                status_q <= (status_q & ~pwdata[irq_ctrl_pkg::NumSrc-1:0]) | (srcReq & ~reqPrev_q);
            end
            else
            begin
                status_q <= status_q | (srcReq & ~reqPrev_q);
            end
        end
    end

    // event mask
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            mask_q <= irq_ctrl_pkg::SrcRst;
        end
        else if (wrAcc && paddr == irq_ctrl_pkg::MaskOff)
        begin
            mask_q <= pwdata[irq_ctrl_pkg::NumSrc-1:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            eventIrq <= 1'b0;
        end
        else
        begin
            eventIrq <= |(status_q & mask_q);
        end
    end

    // ========================================
    // nesting record, push on ack and pop on return
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            inService_q <= '0;
            depth_q     <= '0;
        end
        else if (cpuReti && depth_q != '0)
        begin
            inService_q[curLevel] <= 1'b0; // RULE15
            depth_q               <= depth_q - 1'b1;
        end
        else if (cpuAck && cpuIrq)
        begin
            inService_q[cpuLevel] <= 1'b1; // RULE15
            depth_q               <= depth_q + 1'b1;
        end
    end

    // vector request toward the cpu
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cpuIrq    <= 1'b0;
            cpuVector <= '0;
            cpuLevel  <= '0;
        end
        else
        begin
            cpuIrq    <= preemptOk && !(cpuAck && cpuIrq) && !cpuReti; // RULE6 RULE7
            cpuVector <= win.source;
            cpuLevel  <= win.level;
        end
    end

    // ========================================
    // read mux
    always_comb
    begin
        rdData = '0;
        mapped = 1'b1;
        unique case (paddr)
            irq_ctrl_pkg::EnPrimaryOff:   rdData[7:0] = enPrimary_q;
            irq_ctrl_pkg::EnSecondaryOff: rdData[3:0] = enSecondary_q;
            irq_ctrl_pkg::PrioLowOff:     rdData[6:0] = prioLow_q;
            irq_ctrl_pkg::PrioHighOff:    rdData[6:0] = prioHigh_q;
            irq_ctrl_pkg::PrioLow2Off:    rdData[2:0] = prioLow2_q;
            irq_ctrl_pkg::PrioHigh2Off:   rdData[2:0] = prioHigh2_q;
            irq_ctrl_pkg::StatusOff:      rdData[9:0] = status_q;
            irq_ctrl_pkg::MaskOff:        rdData[9:0] = mask_q;
            irq_ctrl_pkg::BitOpOff:       rdData      = '0;
            irq_ctrl_pkg::ServiceOff:     rdData[7:0] = {1'b0, depth_q, inService_q};
            default:                      mapped      = 1'b0;
        endcase
    end

    // registered answer, ready in the first access cycle
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata  <= (psel && !penable && !pwrite) ? rdData : '0;
        end
    end

    // twoWireReq has no vector in the ten source set; its enable is stored only
    logic unusedTwoWire;
    assign unusedTwoWire = twoWireReq & enSecondary_q[1];

endmodule

// file: verification/irq_cpu_model.sv
/*
 * cpu stand-in: takes a vector some cycles after the request rises and
 * returns from the handler when the bench asks.
 * assumes the controller samples ack and reti on the rising clock edge.
 */
`timescale 1ns/1ps

module irq_cpu_model
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // controller side
    input  wire logic       cpuIrq,
    output logic            cpuAck,
    output logic            cpuReti,
    // bench control, a delay of zero never takes the vector
    input  wire logic [3:0] ackDelay,
    input  wire logic       doReti
);
    logic [3:0] waitCnt_q;

    // ========================================
    // vector taking, one pulse per request
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            waitCnt_q <= 4'h0;
            cpuAck    <= 1'b0;
        end
        else if (cpuIrq && !cpuAck && ackDelay != 4'h0)
        begin
            waitCnt_q <= (waitCnt_q + 4'h1 >= ackDelay) ? 4'h0 : waitCnt_q + 4'h1;
            cpuAck    <= (waitCnt_q + 4'h1 >= ackDelay);
        end
        else
        begin
            waitCnt_q <= 4'h0;
            cpuAck    <= 1'b0;
        end
    end

    // handler return on request
    always_ff @(posedge clk)
    begin
        cpuReti <= srst ? 1'b0 : doReti;
    end
endmodule

// file: verification/irq_ctrl_monitor.sv
/*
 * port checker for the interrupt controller: apb answer and cpu request.
 * assumes a bind to the controller top, every pin by name.
 */
`timescale 1ns/1ps

module irq_ctrl_monitor
(
    // clock and reset
    input  wire logic                            clk,
    input  wire logic                            srst,
    // apb
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [irq_ctrl_pkg::AddrW-1:0]  paddr,
    input  wire logic [31:0]                     pwdata,
    input  wire logic [31:0]                     prdata,
    input  wire logic                            pready,
    input  wire logic                            pslverr,
    // requests and cpu
    input  wire logic [irq_ctrl_pkg::NumSrc-1:0] srcReq,
    input  wire logic                            cpuIrq,
    input  wire logic [irq_ctrl_pkg::LvlW-1:0]   cpuLevel,
    input  wire logic                            cpuAck,
    input  wire logic                            cpuReti
);
    logic globalEn_q;
    logic topBusy_q;

    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    // ========================================
    // shadow of the global enable, by word or by bit operation
    always_ff @(posedge clk)
    begin
        if (srst)
            globalEn_q <= 1'b0;
        else if (psel && penable && pready && pwrite && (paddr == irq_ctrl_pkg::EnPrimaryOff
                 || (paddr == irq_ctrl_pkg::BitOpOff && pwdata[3:0] == 4'h7)))
            globalEn_q <= pwdata[7];
    end

    // a top level handler runs from its ack to the next return
    always_ff @(posedge clk)
    begin
        if (srst || cpuReti)
            topBusy_q <= 1'b0;
        else if (cpuAck && cpuIrq && cpuLevel == 2'h3)
            topBusy_q <= 1'b1;
    end

    // ========================================
    sequence s_access;
        psel && !penable ##1 psel && penable;
    endsequence

    a_ready_after_access: assert property (s_access |-> pready)
        else $error("pready late after access phase");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_rdata_idle_zero: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0)
        else $error("prdata not zero outside a read");
    a_global_gate: assert property ($rose(cpuIrq) |-> globalEn_q)
        else $error("request raised with global enable clear");
    a_irq_has_source: assert property ($rose(cpuIrq) |-> $past(srcReq) != 0 || $past(srcReq, 2) != 0)
        else $error("request raised without a source");
    a_ack_drops_irq: assert property (cpuAck && cpuIrq |=> !cpuIrq)
        else $error("request held after ack");
    a_top_level_hold: assert property (topBusy_q |-> !cpuIrq)
        else $error("top level handler preempted");
endmodule

// file: verification/tb.sv
/*
 * self-checking bench for the interrupt controller over apb.
 * assumes the cpu stand-in model and the port checker bound below.
 */
`timescale 1ns/1ps

module tb;
    logic                            clk;
    logic                            srst;
    logic                            psel;
    logic                            penable;
    logic                            pwrite;
    logic [irq_ctrl_pkg::AddrW-1:0]  paddr;
    logic [31:0]                     pwdata;
    logic [31:0]                     prdata;
    logic [31:0]                     rd;
    logic                            pready;
    logic                            pslverr;
    logic                            err;
    logic [irq_ctrl_pkg::NumSrc-1:0] srcReq;
    logic                            cpuIrq;
    logic [irq_ctrl_pkg::SrcW-1:0]   cpuVector;
    logic [irq_ctrl_pkg::LvlW-1:0]   cpuLevel;
    logic                            cpuAck;
    logic                            cpuReti;
    logic                            eventIrq;
    logic                            doReti;
    int                              failures;
    int                              cmp_count;

    // ========================================
    // design and cpu stand-in
    four_level_interrupt_controller u_dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .srcReq(srcReq), .twoWireReq(1'b0), .cpuIrq(cpuIrq),
        .cpuVector(cpuVector), .cpuLevel(cpuLevel), .cpuAck(cpuAck), .cpuReti(cpuReti),
        .eventIrq(eventIrq));
    irq_cpu_model u_cpu (.clk(clk), .srst(srst), .cpuIrq(cpuIrq), .cpuAck(cpuAck),
        .cpuReti(cpuReti), .ackDelay(4'h4), .doReti(doReti));

    // 40 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ========================================
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic hang(input int n, input int lim);
        if (n >= lim)
        begin
            failures++;
            results();
        end
    endtask

    // one apb transfer, answer kept in rd and err
    task automatic apb(input logic w, input logic [irq_ctrl_pkg::AddrW-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        hang(n, 20);
    endtask

    // wait for a vector, compare it, then wait for it to be taken
    task automatic srv(input logic [3:0] v, input logic [1:0] l);
        int n;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (cpuIrq !== 1'b1 && n < 20);
        chk("vector", 32'(cpuVector), 32'(v));
        chk("level", 32'(cpuLevel), 32'(l));
        while (cpuIrq === 1'b1 && n < 40)
        begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        hang(n, 40);
    endtask

    task automatic quiet(input int c);
        repeat (c)
        begin
            @(negedge clk);
            chk("idle request", 32'(cpuIrq), 32'h0);
        end
        @(posedge clk);
    endtask

    task automatic reti();
        @(posedge clk);
        doReti <= 1'b1;
        @(posedge clk);
        doReti <= 1'b0;
    endtask

    task automatic end_isr();
        @(posedge clk);
        srcReq <= 10'h000;
        reti();
    endtask

    // ========================================
    task automatic t_reset();
        apb(1'b0, irq_ctrl_pkg::EnPrimaryOff, 32'h0);
        chk("enable reset", rd, 32'h0);
        apb(1'b0, irq_ctrl_pkg::PrioHighOff, 32'h0);
        chk("prio high reset", rd, 32'h0);
        apb(1'b0, irq_ctrl_pkg::PrioLowOff, 32'h0);
        chk("prio low reset", rd, 32'h0);
        apb(1'b0, 12'h0f0, 32'h0);
        chk("unmapped error", 32'(err), 32'h1);
    endtask

    task automatic t_gate();
        srcReq <= 10'h001;
        apb(1'b1, irq_ctrl_pkg::EnPrimaryOff, 32'h01);
        quiet(5);
        apb(1'b1, irq_ctrl_pkg::EnPrimaryOff, 32'h80);
        quiet(5);
        apb(1'b1, irq_ctrl_pkg::BitOpOff, 32'h80);
        srv(4'h0, 2'h0);
        apb(1'b0, irq_ctrl_pkg::EnPrimaryOff, 32'h0);
        chk("bit set", rd, 32'h81);
        apb(1'b1, irq_ctrl_pkg::BitOpOff, 32'h07);
        apb(1'b0, irq_ctrl_pkg::EnPrimaryOff, 32'h0);
        chk("bit clear", rd, 32'h01);
        end_isr();
    endtask

    // ext 0 against timer 1 at each level of timer 1
    task automatic t_levels();
        apb(1'b1, irq_ctrl_pkg::EnPrimaryOff, 32'h89);
        for (int lv = 0; lv < 4; lv++)
        begin
            apb(1'b1, irq_ctrl_pkg::PrioLowOff, 32'(lv % 2) << 3);
            apb(1'b1, irq_ctrl_pkg::PrioHighOff, 32'(lv / 2) << 3);
            srcReq <= 10'h009;
            srv(lv == 0 ? 4'h0 : 4'h3, 2'(lv));
            end_isr();
        end
    endtask

    // ext 0 at level 1, timer 1 at 2, timer 0 at 3
    task automatic t_nest();
        apb(1'b1, irq_ctrl_pkg::PrioLowOff, 32'h03);
        apb(1'b1, irq_ctrl_pkg::PrioHighOff, 32'h0a);
        apb(1'b1, irq_ctrl_pkg::EnPrimaryOff, 32'h8b);
        srcReq <= 10'h001;
        srv(4'h0, 2'h1);
        quiet(6);
        srcReq <= 10'h009;
        srv(4'h3, 2'h2);
        srcReq <= 10'h00b;
        srv(4'h1, 2'h3);
        apb(1'b0, irq_ctrl_pkg::ServiceOff, 32'h0);
        chk("service record", rd, 32'h3e);
        srcReq <= 10'h001;
        reti();
        quiet(6);
        reti();
        quiet(6);
        reti();
        srv(4'h0, 2'h1);
        end_isr();
    endtask

    // every source alone at level 0
    task automatic t_all();
        apb(1'b1, irq_ctrl_pkg::PrioLowOff, 32'h0);
        apb(1'b1, irq_ctrl_pkg::PrioHighOff, 32'h0);
        apb(1'b1, irq_ctrl_pkg::EnPrimaryOff, 32'hff);
        apb(1'b1, irq_ctrl_pkg::EnSecondaryOff, 32'h0f);
        for (int i = 0; i < irq_ctrl_pkg::NumSrc; i++)
        begin
            srcReq <= 10'(1 << i);
            srv(4'(i), 2'h0);
            end_isr();
        end
    endtask

    task automatic t_event();
        apb(1'b1, irq_ctrl_pkg::EnPrimaryOff, 32'h0);
        apb(1'b1, irq_ctrl_pkg::StatusOff, 32'h3ff);
        srcReq <= 10'h001;
        apb(1'b0, irq_ctrl_pkg::StatusOff, 32'h0);
        chk("status", rd, 32'h1);
        chk("masked event", 32'(eventIrq), 32'h0);
        apb(1'b1, irq_ctrl_pkg::MaskOff, 32'h1);
        srcReq <= 10'h000;
        repeat (2) @(negedge clk);
        chk("event", 32'(eventIrq), 32'h1);
        apb(1'b1, irq_ctrl_pkg::StatusOff, 32'h1);
        repeat (2) @(negedge clk);
        chk("event cleared", 32'(eventIrq), 32'h0);
    endtask

    // ========================================
    // reset, then every scenario in turn
    initial
    begin
        failures  = 0;
        cmp_count = 0;
        srst      = 1'b1;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = '0;
        pwdata    = 32'h0;
        srcReq    = 10'h000;
        doReti    = 1'b0;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_gate();
        t_levels();
        t_nest();
        t_all();
        t_event();
        results();
    end
endmodule

bind four_level_interrupt_controller irq_ctrl_monitor u_mon (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .srcReq(srcReq), .cpuIrq(cpuIrq), .cpuLevel(cpuLevel),
    .cpuAck(cpuAck), .cpuReti(cpuReti));
